// File: common/ocr_pkg.sv
// ocr_pkg: offsets, reset values and carrier types of the on-chip control register bank
// assumes an 8-bit core external data bus and an 8-bit host port
package ocr_pkg;
  localparam logic [7:0]  PAGE_RESET      = 8'h00;
  localparam logic [7:0]  BANK_PAGE       = 8'h7f;
  localparam logic [15:0] BANK_BASE       = 16'h7f00;
  localparam logic [7:0]  OFF_INT_SRC0    = 8'h00;
  localparam logic [7:0]  OFF_INT_MASK0   = 8'h01;
  localparam logic [7:0]  OFF_RSVD_TOP    = 8'hf0;
  localparam logic [7:0]  OFF_HOST_DATA   = 8'hf1;
  localparam logic [7:0]  OFF_HOST_STAT   = 8'hf2;
  localparam logic [7:0]  OFF_WAKE_TMR    = 8'hf3;
  localparam logic [7:0]  OFF_CONFIG0     = 8'hf4;
  localparam logic [7:0]  OFF_CLK_CTRL    = 8'hf5;
  localparam logic [7:0]  OFF_CLK_IDX_LO  = 8'hf6;
  localparam logic [7:0]  OFF_CLK_VAL_LO  = 8'hf7;
  localparam logic [7:0]  OFF_CLK_IDX_HI  = 8'hf8;
  localparam logic [7:0]  OFF_CLK_VAL_HI  = 8'hf9;
  localparam logic [7:0]  OFF_AUX_DATA    = 8'hfa;
  localparam logic [7:0]  OFF_A20_GATE    = 8'hfb;
  localparam logic [7:0]  OFF_BOOT_CFG    = 8'hfc;
  localparam logic [7:0]  OFF_OBF_CTRL    = 8'hfd;
  localparam logic [7:0]  OFF_A20_SET     = 8'hfe;
  localparam logic [7:0]  OFF_A20_CLR     = 8'hff;
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  localparam logic [7:0]  RST_CLK_CTRL    = 8'h80;
  localparam logic [7:0]  RST_A20_GATE    = 8'h01;
  // host port status and address line 20 gate bit positions
  localparam int          STAT_OBF        = 0;
  localparam int          STAT_IBF        = 1;
  localparam int          STAT_CMD        = 3;
  localparam int          STAT_AUX        = 5;
  localparam int          A20_BIT         = 0;

  typedef enum logic [2:0] {
    OCR_HS_DATA,
    OCR_HS_CMD,
    OCR_HS_CLK_IDX1,
    OCR_HS_CLK_VAL1,
    OCR_HS_CLK_IDX2,
    OCR_HS_CLK_VAL2
  } ocr_host_sel_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indirect;
    logic [7:0] low;
    logic [15:0] data_pointer_pair;
    logic [7:0] wdata;
  } ocr_core_req_t;

  typedef struct packed {
    logic          rd;
    logic          wr;
    ocr_host_sel_t sel;
    logic [7:0]    wdata;
  } ocr_host_req_t;
endpackage : ocr_pkg

// File: hw/ocr_regbank.sv
// ocr_regbank: on-chip control registers decoded in the core's external data page
// assumes core strobes are one-cycle pulses on sys_clk; host strobes come from pins
// Function
// - registers live outside the core, decoded in external data space.
// - core reads or writes every register except the host-only clock pairs, according to its access type.
// - some registers are also reachable from the system host port.
// - core address is base 7F00 plus one-byte offset, one page.
// - indirect moves put page select on upper address byte, reset zero.
`timescale 1ns/1ns
module ocr_regbank
  import ocr_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic          clkEn,
  // core external data bus
  input  wire ocr_core_req_t coreReq,
  input  wire logic          pageWr,
  input  wire logic [7:0]    pageWdata,
  output logic [7:0]         coreRdata,
  output logic [7:0]         externalPageSelect,
  // hardware events into interrupt source 0
  input  wire logic [7:0]    intEvent,
  // system host port (pins)
  input  wire ocr_host_req_t hostReq,
  output logic [7:0]         hostRdata,
  // register outputs steering the rest of the chip
  output logic [7:0]         intPending,
  output logic               addrLine20,
  output logic [7:0]         wakeTimer,
  output logic [7:0]         configurationZero,
  output logic [7:0]         clockCalendarControl,
  output logic [7:0]         bootRomConfiguration,
  output logic [7:0]         hostOutputFullControl
);

  logic [7:0]  interruptSource0;
  logic [7:0]  interruptMask0;
  logic [7:0]  hostWrittenDataIn;
  logic [7:0]  hostReadDataOut;
  logic [7:0]  hostPortStatus;
  logic [7:0]  clkIdxLo;
  logic [7:0]  clkValLo;
  logic [7:0]  clkIdxHi;
  logic [7:0]  clkValHi;
  logic [7:0]  a20Gate;
  logic [7:0]  hostClkIdx1;
  logic [7:0]  hostClkVal1;
  logic [7:0]  hostClkIdx2;
  logic [7:0]  hostClkVal2;
  logic [15:0] coreAddr;
  logic        bankHit;
  logic [7:0]  off;
  logic        cWr;
  logic        cRd;
  logic [2:0]  hWrSync;
  logic [2:0]  hRdSync;
  logic        hWrLevel;
  logic        hRdLevel;
  logic        hWrPulse;
  logic        hRdPulse;
  ocr_host_sel_t hSelSync [3];
  logic [7:0]    hDataSync [3];

  function automatic logic wrAt(input logic [7:0] o, input logic [7:0] target, input logic w);
    wrAt = w && (o == target);
  endfunction : wrAt

  // page select: a core-side register, driven out on indirect moves
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      externalPageSelect <= PAGE_RESET;
    end else if (clkEn && pageWr) begin
      externalPageSelect <= pageWdata;
    end
  end

  // indirect moves take the page as the high byte, else the data pointer
  assign coreAddr = coreReq.indirect ? {externalPageSelect, coreReq.low} : coreReq.data_pointer_pair;
  assign bankHit  = (coreAddr[15:8] == BANK_BASE[15:8]);
  assign off      = coreAddr[7:0];
  assign cWr      = clkEn && coreReq.wr && bankHit;
  assign cRd      = clkEn && coreReq.rd && bankHit;

  // host strobes cross from pins: three flops, act when the last two agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hWrSync  <= 3'h0;
      hRdSync  <= 3'h0;
      hWrLevel <= 1'b0;
      hRdLevel <= 1'b0;
      hSelSync  <= '{default: OCR_HS_DATA};
      hDataSync <= '{default: RST_ZERO};
    end else if (clkEn) begin
      hWrSync <= {hWrSync[1:0], hostReq.wr};
      hRdSync <= {hRdSync[1:0], hostReq.rd};
      hSelSync  <= '{hostReq.sel, hSelSync[0], hSelSync[1]};
      hDataSync <= '{hostReq.wdata, hDataSync[0], hDataSync[1]};
      if (hWrSync[1] == hWrSync[2]) begin
        hWrLevel <= hWrSync[2];
      end
      if (hRdSync[1] == hRdSync[2]) begin
        hRdLevel <= hRdSync[2];
      end
    end
  end

  // select and data ride three flops too, so they line up with the strobe's action
  assign hWrPulse = clkEn && (hWrSync[1] == hWrSync[2]) && hWrSync[2] && !hWrLevel;
  assign hRdPulse = clkEn && (hRdSync[1] == hRdSync[2]) && hRdSync[2] && !hRdLevel;

  // interrupt source 0: event set beats a write-one clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interruptSource0 <= RST_ZERO;
      interruptMask0   <= RST_ZERO;
    end else if (clkEn) begin
      if (wrAt(off, OFF_INT_SRC0, cWr)) begin
        interruptSource0 <= (interruptSource0 & ~coreReq.wdata) | intEvent;
      end else begin
        interruptSource0 <= interruptSource0 | intEvent;
      end
      if (wrAt(off, OFF_INT_MASK0, cWr)) begin
        interruptMask0 <= coreReq.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intPending <= RST_ZERO;
    end else if (clkEn) begin
      intPending <= interruptSource0 & interruptMask0;
    end
  end

  // plain read/write control registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wakeTimer             <= RST_ZERO;
      configurationZero     <= RST_ZERO;
      clockCalendarControl  <= RST_CLK_CTRL;
      clkIdxLo              <= RST_ZERO;
      clkValLo              <= RST_ZERO;
      clkIdxHi              <= RST_ZERO;
      clkValHi              <= RST_ZERO;
      bootRomConfiguration  <= RST_ZERO;
      hostOutputFullControl <= RST_ZERO;
    end else if (cWr) begin
      unique case (off)
        OFF_WAKE_TMR:   wakeTimer             <= coreReq.wdata;
        OFF_CONFIG0:    configurationZero     <= coreReq.wdata;
        OFF_CLK_CTRL:   clockCalendarControl  <= coreReq.wdata;
        OFF_CLK_IDX_LO: clkIdxLo              <= coreReq.wdata;
        OFF_CLK_VAL_LO: clkValLo              <= coreReq.wdata;
        OFF_CLK_IDX_HI: clkIdxHi              <= coreReq.wdata;
        OFF_CLK_VAL_HI: clkValHi              <= coreReq.wdata;
        OFF_BOOT_CFG:   bootRomConfiguration  <= coreReq.wdata;
        OFF_OBF_CTRL:   hostOutputFullControl <= coreReq.wdata;
        default: ; // read-only and unmapped offsets drop the write
      endcase
    end
  end

  // address line 20 gate: direct write plus set/clear strobes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      a20Gate    <= RST_A20_GATE;
      addrLine20 <= RST_A20_GATE[A20_BIT];
    end else if (clkEn) begin
      if (wrAt(off, OFF_A20_GATE, cWr)) begin
        a20Gate <= coreReq.wdata;
      end else if (wrAt(off, OFF_A20_SET, cWr)) begin
        a20Gate[A20_BIT] <= 1'b1;
      end else if (wrAt(off, OFF_A20_CLR, cWr)) begin
        a20Gate[A20_BIT] <= 1'b0;
      end
      addrLine20 <= a20Gate[A20_BIT];
    end
  end

  // host data path: flags set by one side, cleared by the other; set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hostWrittenDataIn <= RST_ZERO;
      hostReadDataOut   <= RST_ZERO;
      hostPortStatus    <= RST_ZERO;
    end else if (clkEn) begin
      if (wrAt(off, OFF_HOST_STAT, cWr)) begin
        hostPortStatus <= coreReq.wdata;
      end else if (cRd && off == OFF_HOST_DATA) begin
        hostPortStatus[STAT_IBF] <= 1'b0;
      end
      if (hRdPulse && hSelSync[2] == OCR_HS_DATA && !wrAt(off, OFF_HOST_DATA, cWr)
          && !wrAt(off, OFF_AUX_DATA, cWr)) begin
        hostPortStatus[STAT_OBF] <= 1'b0;
      end
      if (hWrPulse && (hSelSync[2] == OCR_HS_DATA || hSelSync[2] == OCR_HS_CMD)) begin
        hostWrittenDataIn        <= hDataSync[2];
        hostPortStatus[STAT_IBF] <= 1'b1;
        hostPortStatus[STAT_CMD] <= (hSelSync[2] == OCR_HS_CMD);
      end
      if (wrAt(off, OFF_HOST_DATA, cWr) || wrAt(off, OFF_AUX_DATA, cWr)) begin
        hostReadDataOut          <= coreReq.wdata;
        hostPortStatus[STAT_OBF] <= 1'b1;
        hostPortStatus[STAT_AUX] <= (off == OFF_AUX_DATA);
      end
    end
  end

  // host-only clock index/value pairs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hostClkIdx1 <= RST_ZERO;
      hostClkVal1 <= RST_ZERO;
      hostClkIdx2 <= RST_ZERO;
      hostClkVal2 <= RST_ZERO;
    end else if (hWrPulse) begin
      unique case (hSelSync[2])
        OCR_HS_CLK_IDX1: hostClkIdx1 <= hDataSync[2];
        OCR_HS_CLK_VAL1: hostClkVal1 <= hDataSync[2];
        OCR_HS_CLK_IDX2: hostClkIdx2 <= hDataSync[2];
        OCR_HS_CLK_VAL2: hostClkVal2 <= hDataSync[2];
        default: ;
      endcase
    end
  end

  // host read data, held until the next host read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hostRdata <= RST_ZERO;
    end else if (hRdPulse) begin
      unique case (hSelSync[2])
        OCR_HS_DATA:     hostRdata <= hostReadDataOut;
        OCR_HS_CMD:      hostRdata <= hostPortStatus;
        OCR_HS_CLK_IDX1: hostRdata <= hostClkIdx1;
        OCR_HS_CLK_VAL1: hostRdata <= hostClkVal1;
        OCR_HS_CLK_IDX2: hostRdata <= hostClkIdx2;
        OCR_HS_CLK_VAL2: hostRdata <= hostClkVal2;
        default:         hostRdata <= RST_ZERO;
      endcase
    end
  end

  // core read data: one cycle after the strobe, held until the next read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      coreRdata <= RST_ZERO;
    end else if (clkEn && coreReq.rd) begin
      if (!bankHit) begin
        coreRdata <= RST_ZERO;
      end else begin
        unique case (off)
          OFF_INT_SRC0:   coreRdata <= interruptSource0;
          OFF_INT_MASK0:  coreRdata <= interruptMask0;
          OFF_HOST_DATA:  coreRdata <= hostWrittenDataIn;
          OFF_HOST_STAT:  coreRdata <= hostPortStatus;
          OFF_WAKE_TMR:   coreRdata <= wakeTimer;
          OFF_CONFIG0:    coreRdata <= configurationZero;
          OFF_CLK_CTRL:   coreRdata <= clockCalendarControl;
          OFF_CLK_IDX_LO: coreRdata <= clkIdxLo;
          OFF_CLK_VAL_LO: coreRdata <= clkValLo;
          OFF_CLK_IDX_HI: coreRdata <= clkIdxHi;
          OFF_CLK_VAL_HI: coreRdata <= clkValHi;
          OFF_A20_GATE:   coreRdata <= a20Gate;
          OFF_BOOT_CFG:   coreRdata <= bootRomConfiguration;
          OFF_OBF_CTRL:   coreRdata <= hostOutputFullControl;
          default:        coreRdata <= RST_ZERO; // write-only and gaps
        endcase
      end
    end
  end

  // checks
  chk_page_reset_zero: assert property (@(posedge sys_clk) $rose(resetn) |-> externalPageSelect == PAGE_RESET)
    else $error("page select not zero after reset");
  chk_offpage_read_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && coreReq.rd && !bankHit |=> coreRdata == 8'h00)
    else $error("off-page read returned data");
  chk_indirect_page_use: assert property (@(posedge sys_clk) disable iff (!resetn)
    coreReq.indirect && externalPageSelect != BANK_PAGE |-> !bankHit)
    else $error("indirect access hit bank with wrong page");
  chk_mask_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrAt(off, OFF_INT_MASK0, cWr) ##1 (clkEn && coreReq.rd && bankHit && off == OFF_INT_MASK0)
    |=> coreRdata == $past(coreReq.wdata, 2))
    else $error("mask write not read back");
  chk_event_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && intEvent[0] |=> interruptSource0[0])
    else $error("interrupt event lost");
  chk_a20_set_strobe: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrAt(off, OFF_A20_SET, cWr) ##1 clkEn |=> addrLine20)
    else $error("set strobe did not raise line 20");
  chk_rsvd_write_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrAt(off, OFF_RSVD_TOP, cWr) |=> $stable(configurationZero) && $stable(a20Gate))
    else $error("reserved write changed state");
  chk_host_write_ibf: assert property (@(posedge sys_clk) disable iff (!resetn)
    hWrPulse && hSelSync[2] == OCR_HS_DATA |=> hostPortStatus[STAT_IBF]
    && hostWrittenDataIn == $past(hDataSync[2]))
    else $error("host write not captured");
  chk_core_out_obf: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrAt(off, OFF_HOST_DATA, cWr) |=> hostPortStatus[STAT_OBF])
    else $error("core data write did not set output full");
  cov_host_write: cover property (@(posedge sys_clk) disable iff (!resetn) hWrPulse);
  cov_indirect_hit: cover property (@(posedge sys_clk) disable iff (!resetn) cRd && coreReq.indirect);
  cov_a20_clear: cover property (@(posedge sys_clk) disable iff (!resetn) wrAt(off, OFF_A20_CLR, cWr));

endmodule : ocr_regbank

// File: dv/ocr_core_model.sv
// ocr_core_model: core external data bus master issuing moves into the control page
// assumes a free-running sys_clk; drives at falling edges, one strobe per move
`timescale 1ns/1ns
module ocr_core_model
  import ocr_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // core bus
  output ocr_core_req_t   coreReq,
  output logic            pageWr,
  output logic [7:0]      pageWdata,
  input  wire logic [7:0] coreRdata
);
  initial begin
    coreReq   = '0;
    pageWr    = 1'b0;
    pageWdata = 8'h00;
  end
  // idle bus shows inverted leftovers so a stale address never looks live
  task automatic move(input logic w, input logic ind, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge sys_clk);
    coreReq = '{rd: !w, wr: w, indirect: ind, low: a[7:0], data_pointer_pair: a, wdata: d};
    @(negedge sys_clk);
    coreReq = '{rd: 1'b0, wr: 1'b0, indirect: !ind, low: ~a[7:0], data_pointer_pair: ~a, wdata: ~d};
    @(negedge sys_clk);
    q = coreRdata;
  endtask : move
  // write, then read the same offset on the very next edge
  task automatic write_then_read(input logic [15:0] a, input logic [7:0] d,
                                 output logic [7:0] q);
    @(negedge sys_clk);
    coreReq = '{rd: 1'b0, wr: 1'b1, indirect: 1'b0, low: a[7:0], data_pointer_pair: a, wdata: d};
    @(negedge sys_clk);
    coreReq = '{rd: 1'b1, wr: 1'b0, indirect: 1'b0, low: a[7:0], data_pointer_pair: a, wdata: ~d};
    @(negedge sys_clk);
    coreReq = '{rd: 1'b0, wr: 1'b0, indirect: 1'b1, low: ~a[7:0], data_pointer_pair: ~a, wdata: d};
    q = coreRdata;
  endtask : write_then_read
  task automatic set_page(input logic [7:0] p);
    @(negedge sys_clk);
    pageWr    = 1'b1;
    pageWdata = p;
    @(negedge sys_clk);
    pageWr    = 1'b0;
    pageWdata = ~p;
  endtask : set_page
endmodule : ocr_core_model

// File: dv/ocr_regbank_test.sv
// ocr_regbank_test: self-checking bench for the control register page
// assumes ocr_core_model as core master; host pins driven here at falling edges
`timescale 1ns/1ns
module ocr_regbank_test
  import ocr_pkg::*;
();
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } ocr_row_t;
  logic          sys_clk;
  logic          resetn;
  logic          clkEn;
  ocr_core_req_t coreReq;
  logic          pageWr;
  logic [7:0]    pageWdata;
  logic [7:0]    coreRdata;
  logic [7:0]    externalPageSelect;
  logic [7:0]    intEvent;
  ocr_host_req_t hostReq;
  logic [7:0]    hostRdata;
  logic [7:0]    intPending;
  logic          addrLine20;
  logic [7:0]    wakeTimer;
  logic [7:0]    configurationZero;
  logic [7:0]    clockCalendarControl;
  logic [7:0]    bootRomConfiguration;
  logic [7:0]    hostOutputFullControl;
  logic [7:0]    q;
  int            miscompares;
  int            samples_checked;
  ocr_row_t      rows [12] = '{
    '{16'h7ff3, 8'ha5, 8'ha5}, '{16'h7ff4, 8'h5a, 8'h5a}, '{16'h7ff5, 8'h3c, 8'h3c},
    '{16'h7ff6, 8'hc3, 8'hc3}, '{16'h7ff7, 8'h69, 8'h69}, '{16'h7ff8, 8'h96, 8'h96},
    '{16'h7ff9, 8'h0f, 8'h0f}, '{16'h7ffb, 8'h00, 8'h00}, '{16'h7ffc, 8'hf0, 8'hf0},
    '{16'h7ffd, 8'h81, 8'h81}, '{16'h7f01, 8'h04, 8'h04}, '{16'h7ff0, 8'hff, 8'h00}};

  ocr_regbank u_ocr_regbank (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .coreReq(coreReq),
    .pageWr(pageWr), .pageWdata(pageWdata), .coreRdata(coreRdata), .externalPageSelect(externalPageSelect),
    .intEvent(intEvent), .hostReq(hostReq), .hostRdata(hostRdata), .intPending(intPending),
    .addrLine20(addrLine20), .wakeTimer(wakeTimer), .configurationZero(configurationZero),
    .clockCalendarControl(clockCalendarControl), .bootRomConfiguration(bootRomConfiguration),
    .hostOutputFullControl(hostOutputFullControl));
  ocr_core_model u_ocr_core_model (.sys_clk(sys_clk), .coreReq(coreReq), .pageWr(pageWr),
    .pageWdata(pageWdata), .coreRdata(coreRdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check8

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_ocr_core_model.move(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    u_ocr_core_model.move(1'b0, 1'b0, a, 8'h00, q);
  endtask : rd
  // strobe held well past the three-flop sync, then low long enough to re-arm
  task automatic host(input logic r, input logic w, input ocr_host_sel_t s, input logic [7:0] d);
    @(negedge sys_clk);
    hostReq = '{rd: r, wr: w, sel: s, wdata: d};
    repeat (6) @(negedge sys_clk);
    hostReq = '{rd: 1'b0, wr: 1'b0, sel: s, wdata: ~d};
    repeat (4) @(negedge sys_clk);
  endtask : host

  initial begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end

  initial begin
    resetn   = 1'b0;
    clkEn    = 1'b1;
    intEvent = 8'h00;
    hostReq  = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    check8("page", PAGE_RESET, externalPageSelect);
    rd(16'h7ff5);
    check8("rtcctl", RST_CLK_CTRL, q);
    rd(16'h7ffb);
    check8("gate", RST_A20_GATE, q);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      check8("row", rows[i].exp, q);
    end
    wr(16'h7ef4, 8'h11);
    rd(16'h7ef4);
    check8("offpage", 8'h00, q);
    check8("cfg0", 8'h5a, configurationZero);
    check8("wake", 8'ha5, wakeTimer);
    check8("boot", 8'hf0, bootRomConfiguration);
    check8("obfctl", 8'h81, hostOutputFullControl);
    check8("ctlout", 8'h3c, clockCalendarControl);
    wr(16'h7ffe, 8'h00);
    rd(16'h7ffb);
    check8("gateset", 8'h01, q);
    check8("a20", 8'h01, {7'b0, addrLine20});
    wr(16'h7fff, 8'h00);
    rd(16'h7ffe);
    check8("wo", 8'h00, q);
    check8("a20clr", 8'h00, {7'b0, addrLine20});
    u_ocr_core_model.move(1'b1, 1'b1, 16'h00f3, 8'h77, q);
    rd(16'h7ff3);
    check8("page0", 8'ha5, q);
    u_ocr_core_model.set_page(BANK_PAGE);
    check8("pagesel", BANK_PAGE, externalPageSelect);
    u_ocr_core_model.move(1'b1, 1'b1, 16'h00f3, 8'h77, q);
    u_ocr_core_model.move(1'b0, 1'b1, 16'h00f3, 8'h00, q);
    check8("indirect", 8'h77, q);
    host(1'b0, 1'b1, OCR_HS_DATA, 8'haa);
    rd(16'h7ff2);
    check8("ibf", 8'h02, q);
    rd(16'h7ff1);
    check8("hdata", 8'haa, q);
    rd(16'h7ff2);
    check8("ibfclr", 8'h00, q);
    host(1'b0, 1'b1, OCR_HS_CMD, 8'h55);
    rd(16'h7ff2);
    check8("cmd", 8'h0a, q);
    rd(16'h7ff1);
    wr(16'h7ff1, 8'h33);
    rd(16'h7ff2);
    check8("obf", 8'h09, q);
    host(1'b1, 1'b0, OCR_HS_DATA, 8'h00);
    check8("hread", 8'h33, hostRdata);
    wr(16'h7ffa, 8'h44);
    rd(16'h7ff2);
    check8("aux", 8'h21, q & 8'h21);
    host(1'b0, 1'b1, OCR_HS_CLK_IDX1, 8'h12);
    host(1'b1, 1'b0, OCR_HS_CLK_IDX1, 8'h00);
    check8("hidx", 8'h12, hostRdata);
    @(negedge sys_clk);
    intEvent = 8'h05;
    @(negedge sys_clk);
    intEvent = 8'h00;
    rd(16'h7f00);
    check8("isrc", 8'h05, q);
    check8("ipend", 8'h04, intPending);
    // clear and a fresh event on one edge: the event must survive
    fork
      wr(16'h7f00, 8'h05);
      begin
        @(negedge sys_clk);
        intEvent = 8'h01;
        @(negedge sys_clk);
        intEvent = 8'h00;
      end
    join
    rd(16'h7f00);
    check8("setwins", 8'h01, q);
    wr(16'h7f00, 8'h01);
    rd(16'h7f00);
    check8("iclr", 8'h00, q);
    u_ocr_core_model.write_then_read(16'h7f01, 8'h0c, q);
    check8("b2b", 8'h0c, q);
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    check8("rstcfg", 8'h00, configurationZero);
    check8("rsta20", 8'h01, {7'b0, addrLine20});
    resetn = 1'b1;
    clkEn  = 1'b0;
    wr(16'h7ff4, 8'h77);
    clkEn  = 1'b1;
    rd(16'h7ff4);
    check8("frozen", 8'h00, q);
    wrap_up();
  end
endmodule : ocr_regbank_test
